// File: bench/monitor_status_flag_bank_tb.sv
// Self-checking bench of the status flag register bank
`timescale 1ns/1ps

module monitor_status_flag_bank_tb;
	logic       i_clk, i_rstn, i_wr, i_rd, i_conv_done;
	logic [7:0] i_addr, i_wr_data, o_rd_data, i_fan_over_limit;
	logic       o_rd_valid, i_int_temp_out, i_backup_cell_out;
	logic       i_aux_analog_out, i_int_overtemp_evt, i_any_overtemp_evt;
	logic       i_cooling_evt, i_intrusion_evt, i_intrusion_clear;
	logic [7:0] i_pin_dir_out, i_pin_cfg_lo, i_pin_cfg_hi, i_pin_in;
	logic [7:0] o_pin_out, o_pin_oe, ext;
	logic       i_pin16_dir_out, i_pin16_pol, i_pin16_in;
	logic       o_pin16_out, o_pin16_oe, ext16;
	logic [7:0] rq[$];
	logic [7:0] r;
	int         n_errors, num_checks;

	monitor_status_flag_bank u_dut (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wr(i_wr), .i_wr_data(i_wr_data), .i_rd(i_rd),
		.o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
		.i_conv_done(i_conv_done), .i_fan_over_limit(i_fan_over_limit),
		.i_int_temp_out(i_int_temp_out),
		.i_backup_cell_out(i_backup_cell_out),
		.i_aux_analog_out(i_aux_analog_out),
		.i_int_overtemp_evt(i_int_overtemp_evt),
		.i_any_overtemp_evt(i_any_overtemp_evt),
		.i_cooling_evt(i_cooling_evt), .i_intrusion_evt(i_intrusion_evt),
		.i_intrusion_clear(i_intrusion_clear),
		.i_pin_dir_out(i_pin_dir_out), .i_pin_cfg_lo(i_pin_cfg_lo),
		.i_pin_cfg_hi(i_pin_cfg_hi), .i_pin16_dir_out(i_pin16_dir_out),
		.i_pin16_pol(i_pin16_pol), .i_pin_in(i_pin_in),
		.o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
		.i_pin16_in(i_pin16_in), .o_pin16_out(o_pin16_out),
		.o_pin16_oe(o_pin16_oe));

	pin_side_model u_pins (.i_oe(o_pin_oe), .i_out(o_pin_out),
		.i_ext(ext), .o_pin(i_pin_in));

	// Pin 16 wire
	assign i_pin16_in = o_pin16_oe ? o_pin16_out : ext16;

	// Clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Pseudo-random byte source
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] rd_data exp %h got %h", e, s);
		end
	endtask

	task automatic cmp_pin(input string n, input logic [7:0] e,
		input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask

	// Read strobe, expected byte noted in the queue
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		rq.push_back(e);
		@(posedge i_clk);
		i_rd <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Conversion end with fan flags and int/backup/aux results
	task automatic cv(input logic [7:0] f, input logic [2:0] t);
		@(posedge i_clk);
		i_fan_over_limit <= f;
		{i_aux_analog_out, i_backup_cell_out, i_int_temp_out} <= t;
		i_conv_done <= 1'b1;
		@(posedge i_clk);
		i_conv_done <= 1'b0;
	endtask

	// Event pulses: int, any, cooling, intrusion, intrusion clear
	task automatic ev(input logic [4:0] m);
		@(posedge i_clk);
		{i_int_overtemp_evt, i_any_overtemp_evt, i_cooling_evt,
			i_intrusion_evt, i_intrusion_clear} <= m;
		@(posedge i_clk);
		{i_int_overtemp_evt, i_any_overtemp_evt, i_cooling_evt,
			i_intrusion_evt, i_intrusion_clear} <= 5'h00;
	endtask

	task automatic give_verdict;
		if (rq.size() != 0) begin
			n_errors++;
			$display("[FAIL] rd_queue exp 0 got %0d", rq.size());
		end
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Read answers taken off the queue in order
	always @(negedge i_clk) begin
		if (o_rd_valid === 1'b1) begin
			if (rq.size() == 0) begin
				n_errors++;
				$display("[FAIL] rd_valid exp 0 got 1");
			end else
				cmp_rd(rq.pop_front(), o_rd_data);
		end
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge i_clk);
		n_errors++;
		give_verdict();
	end

	initial begin
		{i_rstn, i_wr, i_rd, i_conv_done, i_int_temp_out} = 5'h00;
		{i_backup_cell_out, i_aux_analog_out, i_int_overtemp_evt} = 3'h0;
		{i_any_overtemp_evt, i_cooling_evt, i_intrusion_evt} = 3'h0;
		{i_intrusion_clear, i_pin16_dir_out, i_pin16_pol, ext16} = 4'h2;
		{i_addr, i_wr_data, i_fan_over_limit, ext} = 32'h0;
		{i_pin_dir_out, i_pin_cfg_lo, i_pin_cfg_hi} = 24'h0;
		r = 8'h0F;
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h00);
		// Fan flags from random limit results
		for (int k = 0; k < 4; k++) begin
			r = lfsr(r);
			cv(r, 3'h7);
			rd(8'h22, r);
		end
		wr(8'h22, ~r);
		rd(8'h22, r);
		rd(8'h23, 8'h07);
		cv(8'h00, 3'h0);
		rd(8'h23, 8'h00);
		rd(8'h30, 8'h00);
		// Set-once events, cleared by the read, intrusion only by its own clear
		ev(5'h10);
		rd(8'h23, 8'h01);
		rd(8'h23, 8'h00);
		ev(5'h08);
		rd(8'h23, 8'h08);
		rd(8'h23, 8'h00);
		ev(5'h04);
		rd(8'h23, 8'h10);
		rd(8'h23, 8'h00);
		ev(5'h02);
		rd(8'h23, 8'h40);
		rd(8'h23, 8'h40);
		ev(5'h01);
		rd(8'h23, 8'h00);
		// Pin 16 as input, then as output, active high
		i_pin16_pol <= 1'b1;
		wr(8'h23, 8'hFF);
		rd(8'h23, 8'h00);
		ext16 <= 1'b1;
		rd(8'h23, 8'h80);
		i_pin16_dir_out <= 1'b1;
		wr(8'h23, 8'h00);
		@(negedge i_clk);
		cmp_pin("pin16", 8'h02, {6'h00, o_pin16_oe, o_pin16_out});
		wr(8'h23, 8'h80);
		@(negedge i_clk);
		cmp_pin("pin16", 8'h03, {6'h00, o_pin16_oe, o_pin16_out});
		@(posedge i_clk);
		// Pins 0-7 as inputs, both polarities
		r = lfsr(r);
		ext <= r;
		{i_pin_cfg_lo, i_pin_cfg_hi} <= 16'hAAAA;
		rd(8'h24, r);
		{i_pin_cfg_lo, i_pin_cfg_hi} <= 16'hAA00;
		rd(8'h24, r ^ 8'hF0);
		{i_pin_cfg_lo, i_pin_cfg_hi} <= 16'h0000;
		rd(8'h24, ~r);
		wr(8'h24, r);
		rd(8'h24, ~r);
		// Pins 0-7 as outputs
		i_pin_dir_out <= 8'hFF;
		{i_pin_cfg_lo, i_pin_cfg_hi} <= 16'hAAAA;
		wr(8'h24, 8'h5A);
		@(negedge i_clk);
		cmp_pin("pin_out", 8'h5A, o_pin_out);
		cmp_pin("pin_oe", 8'hFF, o_pin_oe);
		rd(8'h24, 8'h5A);
		{i_pin_cfg_lo, i_pin_cfg_hi} <= 16'h0000;
		repeat (3) @(posedge i_clk);
		cmp_pin("pin_out", 8'hA5, o_pin_out);
		repeat (4) @(posedge i_clk);
		give_verdict();
	end
endmodule

// File: bench/pin_side_model.sv
// Outside world of the general pins: resolves each pin wire
`timescale 1ns/1ps

module pin_side_model (
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_ext,
	output logic      [7:0] o_pin
);
	// Device level where it drives, outside source elsewhere
	assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// File: hw/general_pin_bank.sv
// General-purpose pin status bits with polarity and direction handling
`timescale 1ns/1ps
`include "monitor_status_regs.svh"

module general_pin_bank #(
	parameter int N = 8
) (
	input  wire logic         i_clk,
	input  wire logic         i_rstn,
	input  wire logic [N-1:0] i_dir_out,
	input  wire logic [N-1:0] i_pol,
	input  wire logic [N-1:0] i_pin_in,
	input  wire logic         i_wr,
	input  wire logic [N-1:0] i_wr_data,
	output logic      [N-1:0] o_status,
	output logic      [N-1:0] o_pin_out,
	output logic      [N-1:0] o_pin_oe
);

	logic [N-1:0] status_q;
	logic [N-1:0] status_d;
	logic [N-1:0] pin_out_q;
	logic [N-1:0] pin_oe_q;

	// Input pins show asserted level, output pins keep written value
	always_comb begin
		for (int k = 0; k < N; k++) begin
			if (!i_dir_out[k]) begin
				status_d[k] = (i_pin_in[k] == i_pol[k]);
			end else if (i_wr) begin
				status_d[k] = i_wr_data[k];
			end else begin
				status_d[k] = status_q[k];
			end
		end
	end

	// Status bits
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	// Pin drive: asserted level follows polarity, high polarity = high
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pin_out_q <= '0;
			pin_oe_q  <= '0;
		end else begin
			pin_out_q <= ~(status_d ^ i_pol);
			pin_oe_q  <= i_dir_out;
		end
	end

	assign o_status  = status_q;
	assign o_pin_out = pin_out_q;
	assign o_pin_oe  = pin_oe_q;

	// Input pins read their asserted state one edge later
	chk_pin_input: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!i_dir_out[0] |=> status_q[0] == ($past(i_pin_in[0]) == $past(i_pol[0])))
		else $error("input pin status wrong");

	// Writes land on output pins and drive the asserted level
	chk_pin_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_wr && i_dir_out[0] |=> status_q[0] == $past(i_wr_data[0])
			&& pin_out_q[0] == ~($past(i_wr_data[0]) ^ $past(i_pol[0])))
		else $error("output pin write not applied");

	// Writes to an input pin are ignored
	chk_pin_readonly: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_wr && !i_dir_out[0] && (i_pin_in[0] != i_pol[0]) |=> !status_q[0])
		else $error("input pin bit took a write");

endmodule

// File: hw/monitor_status_flag_bank.sv
// Status flag register bank of the system monitor
`timescale 1ns/1ps
`include "monitor_status_regs.svh"

module monitor_status_flag_bank (
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wr_data,
	input  wire logic       i_rd,
	output logic      [7:0] o_rd_data,
	output logic            o_rd_valid,
	// Measurement results, sampled on conversion end
	input  wire logic       i_conv_done,
	input  wire logic [7:0] i_fan_over_limit,
	input  wire logic       i_int_temp_out,
	input  wire logic       i_backup_cell_out,
	input  wire logic       i_aux_analog_out,
	// Event pulses
	input  wire logic       i_int_overtemp_evt,
	input  wire logic       i_any_overtemp_evt,
	input  wire logic       i_cooling_evt,
	input  wire logic       i_intrusion_evt,
	input  wire logic       i_intrusion_clear,
	// Pin configuration
	input  wire logic [7:0] i_pin_dir_out,
	input  wire logic [7:0] i_pin_cfg_lo,
	input  wire logic [7:0] i_pin_cfg_hi,
	input  wire logic       i_pin16_dir_out,
	input  wire logic       i_pin16_pol,
	// Pins
	input  wire logic [7:0] i_pin_in,
	output logic      [7:0] o_pin_out,
	output logic      [7:0] o_pin_oe,
	input  wire logic       i_pin16_in,
	output logic            o_pin16_out,
	output logic            o_pin16_oe
);

	monitor_status_pkg::flag_byte_t fan_q;
	logic                           int_limit_q;
	logic                           int_evt_q;
	logic                           cell_q;
	logic                           aux_q;
	logic                           overtemp_q;
	logic                           cooling_q;
	logic                           intrusion_q;
	logic [7:0]                     pin_lo_status;
	logic                           pin16_status;
	logic [7:0]                     pin_pol;
	monitor_status_pkg::flag_byte_t misc_flags;
	monitor_status_pkg::flag_byte_t rd_data_q;
	logic                           rd_valid_q;
	logic                           rd_misc;
	logic                           wr_misc;
	logic                           wr_pin_lo;

	// Offset decode, also used for read side effects
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// Polarity of pin k sits at odd bit 2(k mod 4)+1 of its config register (lo for pins 0-3, hi for 4-7)
	function automatic logic [7:0] pick_pol(input logic [7:0] lo,
		input logic [7:0] hi);
		logic [7:0] p;
		p = '0;
		for (int k = 0; k < 4; k++) begin
			p[k]     = lo[2*k+1];
			p[k + 4] = hi[2*k+1];
		end
		pick_pol = p;
	endfunction

	assign pin_pol   = pick_pol(i_pin_cfg_lo, i_pin_cfg_hi);
	assign rd_misc   = i_rd && hit(i_addr, `MISC_FLAGS_OFS);
	assign wr_misc   = i_wr && hit(i_addr, `MISC_FLAGS_OFS);
	assign wr_pin_lo = i_wr && hit(i_addr, `PIN_LOW_OFS);

	// Limit flags follow the last conversion
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fan_q       <= `FLAGS_RESET_VAL;
			int_limit_q <= 1'b0;
			cell_q      <= 1'b0;
			aux_q       <= 1'b0;
		end else if (i_conv_done) begin
			fan_q       <= i_fan_over_limit;
			int_limit_q <= i_int_temp_out;
			cell_q      <= i_backup_cell_out;
			aux_q       <= i_aux_analog_out;
		end
	end

	// One-shot event flags, cleared by reading, a new event wins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			int_evt_q  <= 1'b0;
			overtemp_q <= 1'b0;
			cooling_q  <= 1'b0;
		end else begin
			int_evt_q  <= i_int_overtemp_evt | (int_evt_q & ~rd_misc);
			overtemp_q <= i_any_overtemp_evt | (overtemp_q & ~rd_misc);
			cooling_q  <= i_cooling_evt | (cooling_q & ~rd_misc);
		end
	end

	// Intrusion latch, held until its own clear
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			intrusion_q <= 1'b0;
		end else begin
			intrusion_q <= i_intrusion_evt
				| (intrusion_q & ~i_intrusion_clear);
		end
	end

	// Misc flag register image
	always_comb begin
		misc_flags                  = `FLAGS_RESET_VAL;
		misc_flags[`INT_TEMP_BIT]    = int_limit_q | int_evt_q;
		misc_flags[`BACKUP_CELL_BIT] = cell_q;
		misc_flags[`AUX_ANALOG_BIT]  = aux_q;
		misc_flags[`OVERTEMP_BIT]    = overtemp_q;
		misc_flags[`COOLING_BIT]     = cooling_q;
		misc_flags[`UNUSED_BIT]      = 1'b0;
		misc_flags[`INTRUSION_BIT]   = intrusion_q;
		misc_flags[`PIN16_BIT]       = pin16_status;
	end

	// Read answer, one edge after the strobe
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_data_q  <= `FLAGS_RESET_VAL;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= i_rd;
			if (i_rd) begin
				if (hit(i_addr, `FAN_FLAGS_OFS)) begin
					rd_data_q <= fan_q;
				end else if (hit(i_addr, `MISC_FLAGS_OFS)) begin
					rd_data_q <= misc_flags;
				end else if (hit(i_addr, `PIN_LOW_OFS)) begin
					rd_data_q <= pin_lo_status;
				end else begin
					rd_data_q <= `UNMAPPED_VAL;
				end
			end
		end
	end

	assign o_rd_data  = rd_data_q;
	assign o_rd_valid = rd_valid_q;

	// Pins 0 to 7
	general_pin_bank #(.N(8)) u_pin_lo (
		.i_clk     (i_clk),
		.i_rstn    (i_rstn),
		.i_dir_out (i_pin_dir_out),
		.i_pol     (pin_pol),
		.i_pin_in  (i_pin_in),
		.i_wr      (wr_pin_lo),
		.i_wr_data (i_wr_data),
		.o_status  (pin_lo_status),
		.o_pin_out (o_pin_out),
		.o_pin_oe  (o_pin_oe)
	);

	// Pin 16, its bit lives in the misc flag register
	general_pin_bank #(.N(1)) u_pin16 (
		.i_clk     (i_clk),
		.i_rstn    (i_rstn),
		.i_dir_out (i_pin16_dir_out),
		.i_pol     (i_pin16_pol),
		.i_pin_in  (i_pin16_in),
		.i_wr      (wr_misc),
		.i_wr_data (i_wr_data[`PIN16_BIT]),
		.o_status  (pin16_status),
		.o_pin_out (o_pin16_out),
		.o_pin_oe  (o_pin16_oe)
	);

	// Fan flags copy the conversion result
	chk_fan_capture: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_conv_done |=> fan_q == $past(i_fan_over_limit))
		else $error("fan flags not captured");

	// Internal temperature limit shows in bit 0
	chk_int_limit: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_conv_done && i_int_temp_out |=> misc_flags[0])
		else $error("internal limit flag missing");

	// Internal overtemperature transitions set bit 0 until read
	chk_int_event: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_int_overtemp_evt ##1 !rd_misc |=> int_evt_q)
		else $error("internal overtemp event lost");

	// Cell and aux flags follow the conversion
	chk_cell_aux: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_conv_done |=> misc_flags[2:1] ==
			{$past(i_aux_analog_out), $past(i_backup_cell_out)})
		else $error("cell or aux flag wrong");

	// Any overtemperature transition sets bit 3
	chk_overtemp_evt: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_any_overtemp_evt |=> misc_flags[3])
		else $error("overtemp flag not set");

	// Cooling switch sets bit 4, a read clears it
	chk_cooling_evt: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_cooling_evt |=> misc_flags[4] and
			((rd_misc && !i_cooling_evt) |=> !misc_flags[4]))
		else $error("cooling flag set or clear wrong");

	// Unused bit reads zero
	chk_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		rd_valid_q && $past(rd_misc) |-> !rd_data_q[5])
		else $error("unused bit read as one");

	// Intrusion stays latched without a clear
	chk_intrusion_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		intrusion_q && !i_intrusion_clear |=> intrusion_q)
		else $error("intrusion latch dropped");

	// Fan register read returns the flags
	chk_fan_read: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		i_rd && hit(i_addr, `FAN_FLAGS_OFS) |=>
			rd_valid_q && rd_data_q == $past(fan_q))
		else $error("fan register read wrong");

	// Fan flags hold between conversions
	chk_fan_hold: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		!i_conv_done |=> fan_q == $past(fan_q))
		else $error("fan flags changed without conversion");

	// Misc read returns the image from before the clear
	chk_misc_read: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		rd_misc |=> rd_valid_q && rd_data_q == $past(misc_flags))
		else $error("misc register read wrong");

	// Limit results hold between conversions
	chk_limit_hold: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		!i_conv_done |=> {int_limit_q, cell_q, aux_q} ==
			$past({int_limit_q, cell_q, aux_q}))
		else $error("limit flags changed without conversion");

	// Read clears the internal event part of bit 0
	chk_int_clear: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		rd_misc && !i_int_overtemp_evt |=> !int_evt_q)
		else $error("internal event not cleared");

	// Read clears bit 3 unless a new event arrives
	chk_overtemp_clear: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		rd_misc && !i_any_overtemp_evt |=> !misc_flags[3])
		else $error("overtemp flag not cleared");

	// Cooling flag stays set until read
	chk_cooling_hold: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		misc_flags[4] && !rd_misc |=> misc_flags[4])
		else $error("cooling flag dropped");

	// Intrusion event sets bit 6
	chk_intrusion_set: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		i_intrusion_evt |=> misc_flags[6])
		else $error("intrusion flag not set");

	// Pin 16 input shows its asserted state in bit 7
	chk_pin16_input: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		!i_pin16_dir_out |=> misc_flags[7] ==
			($past(i_pin16_in) == $past(i_pin16_pol)))
		else $error("pin 16 input status wrong");

	// Pin 16 write drives the asserted level
	chk_pin16_drive: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		wr_misc && i_pin16_dir_out |=> o_pin16_oe && o_pin16_out ==
			($past(i_wr_data[`PIN16_BIT]) == $past(i_pin16_pol)))
		else $error("pin 16 drive wrong");

	// Pin 0 to 7 register read returns the status bits
	chk_pin_lo_read: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		i_rd && hit(i_addr, `PIN_LOW_OFS) |=>
			rd_valid_q && rd_data_q == $past(pin_lo_status))
		else $error("pin status read wrong");

	// Polarity comes from the odd bits of both config registers
	chk_pol_pick: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		pin_pol == {i_pin_cfg_hi[7], i_pin_cfg_hi[5], i_pin_cfg_hi[3],
			i_pin_cfg_hi[1], i_pin_cfg_lo[7], i_pin_cfg_lo[5],
			i_pin_cfg_lo[3], i_pin_cfg_lo[1]})
		else $error("pin polarity mapping wrong");

endmodule

// File: hw/monitor_status_pkg.sv
// Types shared by the status flag bank files
package monitor_status_pkg;

	typedef logic [7:0] flag_byte_t;
	typedef logic [7:0] reg_addr_t;

endpackage

// File: hw/monitor_status_regs.svh
// Offsets, field positions and reset values of the status flag bank
`ifndef MONITOR_STATUS_REGS_SVH
`define MONITOR_STATUS_REGS_SVH

// Register offsets
`define FAN_FLAGS_OFS     8'h22
`define MISC_FLAGS_OFS    8'h23
`define PIN_LOW_OFS       8'h24

// Power-on value of every flag register
`define FLAGS_RESET_VAL   8'h00

// Field positions in the misc event flag register
`define INT_TEMP_BIT      3'd0
`define BACKUP_CELL_BIT   3'd1
`define AUX_ANALOG_BIT    3'd2
`define OVERTEMP_BIT      3'd3
`define COOLING_BIT       3'd4
`define UNUSED_BIT        3'd5
`define INTRUSION_BIT     3'd6
`define PIN16_BIT         3'd7

// Read answer for an unmapped offset
`define UNMAPPED_VAL      8'h00

`endif
